// ### include/tcg_regs.vh
`ifndef TCG_REGS_VH
`define TCG_REGS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define TCG_ADDR_C_BUF    12'h000
`define TCG_ADDR_FLAGS    12'h004
`define TCG_ADDR_MASK     12'h008
`define TCG_ADDR_B_CTRL   12'h00c
`define TCG_ADDR_B_BUFA   12'h010
`define TCG_ADDR_B_BUFB   12'h014
`define TCG_ADDR_A_CTRL   12'h018
`define TCG_ADDR_A_BUFH   12'h01c
`define TCG_ADDR_A_BUFL   12'h020
// ----------------------------------------
// field positions
// ----------------------------------------
`define TCG_FLAG_B        0
`define TCG_FLAG_C        2
`define TCG_FLAG_A        6
`define TCG_B_CAP_BIT     7
`define TCG_B_RUN_BIT     6
`define TCG_B_CKS_HI      5
`define TCG_B_CKS_LO      4
`define TCG_B_MODE_BIT    3
`define TCG_A_MODE_BIT    4
`define TCG_A_RUN_BIT     3
`define TCG_A_CKS_HI      2
`define TCG_A_CKS_LO      0
`define TCG_C_RUN_BIT     0
// ----------------------------------------
// reset values
// ----------------------------------------
`define TCG_RST_BYTE      8'h00
// ----------------------------------------
// divider exponents
// ----------------------------------------
`define TCG_DIV_B0        12
`define TCG_DIV_B1        10
`define TCG_DIV_B2        7
`define TCG_DIV_A0        23
`define TCG_DIV_A1        13
`define TCG_DIV_A2        8
`define TCG_DIV_A3        3
`define TCG_DIV_C         8
`endif

// ### logic/tcg_pin_edge.v
`default_nettype none
// ----------------------------------------
// synchronised rising edge of a pin
// ----------------------------------------
module tcg_pin_edge (
  input  wire ref_clk,   // core clock
  input  wire rst_n,     // sync reset, low
  input  wire pinIn,     // raw pin
  output reg  risePulse  // one-cycle edge pulse
);
  reg syncA_r;
  reg syncB_r;
  reg last_r;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      syncA_r   <= 1'b0;
      syncB_r   <= 1'b0;
      last_r    <= 1'b0;
      risePulse <= 1'b0;
    end else begin
      syncA_r   <= pinIn;
      syncB_r   <= syncA_r;
      last_r    <= syncB_r;
      risePulse <= syncB_r & ~last_r;
    end
  end
endmodule
`default_nettype wire

// ### logic/tcg_timer_group.v
// Implementation choices: register access over APB and the placing of the registers.
`include "tcg_regs.vh"
`default_nettype none
// Summary of operation
// - timer C has an 8-bit data buffer
// - timer C match sets flag bit 2
// - timer A match sets flag bit 6
// - timer B event sets flag bit 0
// - flag reads one while request pending
// - writes clear flags, never set them
// - flag read returns flags AND mask
// - writing one to bit 7 captures count
// - timer B run bit; stop clears count
// - timer B clock select, bits 5:4
// - timer B bit 3 selects capture mode
// - timer B has buffers A and B
// - reset keeps timer B buffers
// - timer A bit 4 selects window mode
// - timer A run bit; stop clears count
// - timer A clock select, bits 2:0
// - timer A high buffer byte register
// - timer A low buffer byte register
// - timer A control high bits show conversion
module tcg_timer_group #(
  parameter DIV_W = 24  // prescaler width
) (
  input  wire        ref_clk,     // 20 MHz core clock
  input  wire        rst_n,       // sync reset, low
  input  wire        psel,        // apb select
  input  wire        penable,     // apb enable
  input  wire        pwrite,      // apb direction
  input  wire [11:0] paddr,       // apb byte address
  input  wire [31:0] pwdata,      // apb write data
  output reg  [31:0] prdata,      // apb read data
  output reg         pready,      // apb ready
  output reg         pslverr,     // apb error
  input  wire        timerAPin,   // timer A external clock
  input  wire        timerBPin,   // timer B external clock / capture
  input  wire        timerCPin,   // timer C external clock
  input  wire [1:0]  convLowBits, // conversion result low bits
  output reg  [2:0]  irqFlags     // raw flags C, A, B
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0]       cBuf_r;
  reg [7:0]       flags_r;
  reg [7:0]       mask_r;
  reg [7:0]       bCtrl_r;
  reg [7:0]       bBufA_r;
  reg [7:0]       bBufB_r;
  reg [4:0]       aCtrl_r;
  reg [7:0]       aBufH_r;
  reg [7:0]       aBufL_r;
  reg             cRun_r;
  reg [7:0]       bCnt_r;
  reg [15:0]      aCnt_r;
  reg [7:0]       cCnt_r;
  reg [DIV_W-1:0] div_r;
  reg [DIV_W-1:0] divLast_r;

  wire aEdge;
  wire bEdge;
  wire cEdge;

  tcg_pin_edge uEdgeA (.ref_clk(ref_clk), .rst_n(rst_n), .pinIn(timerAPin), .risePulse(aEdge));
  tcg_pin_edge uEdgeB (.ref_clk(ref_clk), .rst_n(rst_n), .pinIn(timerBPin), .risePulse(bEdge));
  tcg_pin_edge uEdgeC (.ref_clk(ref_clk), .rst_n(rst_n), .pinIn(timerCPin), .risePulse(cEdge));

  // ----------------------------------------
  // prescaler: tap k pulses once per 2^(k+1) cycles
  // ----------------------------------------
  wire [DIV_W-1:0] divNxt = div_r + {{(DIV_W-1){1'b0}}, 1'b1};
  wire [DIV_W-1:0] tick   = divNxt & ~div_r;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      div_r     <= {DIV_W{1'b0}};
      divLast_r <= {DIV_W{1'b0}};
    end else begin
      div_r     <= divNxt;
      divLast_r <= tick;
    end
  end

  // ----------------------------------------
  // count enables
  // ----------------------------------------
  wire [1:0] bSel = bCtrl_r[`TCG_B_CKS_HI:`TCG_B_CKS_LO];
  wire [2:0] aSel = aCtrl_r[`TCG_A_CKS_HI:`TCG_A_CKS_LO];
  reg        bInc;
  reg        aInc;

  always @* begin
    case (bSel)
      2'h0:    bInc = divLast_r[`TCG_DIV_B0 - 1];
      2'h1:    bInc = divLast_r[`TCG_DIV_B1 - 1];
      2'h2:    bInc = divLast_r[`TCG_DIV_B2 - 1];
      default: bInc = bEdge;
    endcase
  end

  always @* begin
    case (aSel)
      3'h0:    aInc = divLast_r[`TCG_DIV_A0 - 1];
      3'h1:    aInc = divLast_r[`TCG_DIV_A1 - 1];
      3'h2:    aInc = divLast_r[`TCG_DIV_A2 - 1];
      3'h3:    aInc = divLast_r[`TCG_DIV_A3 - 1];
      3'h4:    aInc = 1'b1;
      3'h7:    aInc = aEdge;
      default: aInc = 1'b0;
    endcase
  end

  wire cInc = cEdge | divLast_r[`TCG_DIV_C - 1];

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire acc    = psel & penable;
  wire wrAcc  = acc & pwrite;
  wire known  = (paddr == `TCG_ADDR_C_BUF) | (paddr == `TCG_ADDR_FLAGS) |
                (paddr == `TCG_ADDR_MASK)  | (paddr == `TCG_ADDR_B_CTRL) |
                (paddr == `TCG_ADDR_B_BUFA) | (paddr == `TCG_ADDR_B_BUFB) |
                (paddr == `TCG_ADDR_A_CTRL) | (paddr == `TCG_ADDR_A_BUFH) |
                (paddr == `TCG_ADDR_A_BUFL);
  wire wrFlag = wrAcc & (paddr == `TCG_ADDR_FLAGS);
  wire wrBCtl = wrAcc & (paddr == `TCG_ADDR_B_CTRL);
  wire softCap = wrBCtl & pwdata[`TCG_B_CAP_BIT];

  // ----------------------------------------
  // timer B: count, match or capture
  // ----------------------------------------
  wire bRun    = bCtrl_r[`TCG_B_RUN_BIT];
  wire bCapMd  = bCtrl_r[`TCG_B_MODE_BIT];
  wire bMatch  = bRun & ~bCapMd & bInc & (bCnt_r == bBufA_r);
  wire bHwCap  = bRun & bCapMd & bEdge;
  wire bEvent  = bMatch | bHwCap;

  always @(posedge ref_clk) begin
    if (!rst_n || !bRun) begin
      bCnt_r <= 8'h00;
    end else if (bMatch) begin
      bCnt_r <= 8'h00;
    end else if (bInc && !(bCapMd && bSel == 2'h3)) begin
      bCnt_r <= bCnt_r + 8'h01;
    end
  end

  // buffers hold across reset: no reset branch
  always @(posedge ref_clk) begin
    if (wrAcc && paddr == `TCG_ADDR_B_BUFA) begin
      bBufA_r <= pwdata[7:0];
    end
    if (wrAcc && paddr == `TCG_ADDR_B_BUFB) begin
      bBufB_r <= pwdata[7:0];
    end else if (bHwCap || softCap) begin
      bBufB_r <= bCnt_r;
    end
  end

  // ----------------------------------------
  // timer A: count or window gate
  // ----------------------------------------
  wire aRun    = aCtrl_r[`TCG_A_RUN_BIT];
  wire aWinMd  = aCtrl_r[`TCG_A_MODE_BIT];
  wire aGate   = ~aWinMd | timerAPin;
  wire aMatch  = aRun & aInc & aGate & (aCnt_r == {aBufH_r, aBufL_r});

  always @(posedge ref_clk) begin
    if (!rst_n || !aRun) begin
      aCnt_r <= 16'h0000;
    end else if (aMatch) begin
      aCnt_r <= 16'h0000;
    end else if (aInc && aGate) begin
      aCnt_r <= aCnt_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // timer C: count to buffer
  // ----------------------------------------
  wire cMatch = cRun_r & cInc & (cCnt_r == cBuf_r);

  always @(posedge ref_clk) begin
    if (!rst_n || !cRun_r) begin
      cCnt_r <= 8'h00;
    end else if (cMatch) begin
      cCnt_r <= 8'h00;
    end else if (cInc) begin
      cCnt_r <= cCnt_r + 8'h01;
    end
  end

  // ----------------------------------------
  // software registers and flags
  // ----------------------------------------
  wire [7:0] setMask = ({7'h00, bEvent} << `TCG_FLAG_B) |
                       ({7'h00, cMatch} << `TCG_FLAG_C) |
                       ({7'h00, aMatch} << `TCG_FLAG_A);
  wire [7:0] flagMask = (8'h01 << `TCG_FLAG_B) | (8'h01 << `TCG_FLAG_C) |
                        (8'h01 << `TCG_FLAG_A);
  reg  [7:0] flags_nxt;

  always @* begin
    flags_nxt = flags_r;
    if (wrFlag) begin
      flags_nxt = flags_r & pwdata[7:0];
    end
    flags_nxt = (flags_nxt | setMask) & flagMask;
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cBuf_r   <= `TCG_RST_BYTE;
      flags_r  <= `TCG_RST_BYTE;
      mask_r   <= `TCG_RST_BYTE;
      bCtrl_r  <= `TCG_RST_BYTE;
      aCtrl_r  <= 5'h00;
      aBufH_r  <= `TCG_RST_BYTE;
      aBufL_r  <= `TCG_RST_BYTE;
      cRun_r   <= 1'b0;
      irqFlags <= 3'h0;
    end else begin
      flags_r  <= flags_nxt;
      irqFlags <= {flags_nxt[`TCG_FLAG_C], flags_nxt[`TCG_FLAG_A], flags_nxt[`TCG_FLAG_B]};
      if (wrAcc && paddr == `TCG_ADDR_C_BUF) begin
        cBuf_r <= pwdata[7:0];
        cRun_r <= pwdata[8 + `TCG_C_RUN_BIT];
      end
      if (wrAcc && paddr == `TCG_ADDR_MASK) begin
        mask_r <= pwdata[7:0];
      end
      if (wrBCtl) begin
        bCtrl_r <= {1'b0, pwdata[6:3], 3'h0};           // capture bit self-clears
      end
      if (wrAcc && paddr == `TCG_ADDR_A_CTRL) begin
        aCtrl_r <= pwdata[4:0];
      end
      if (wrAcc && paddr == `TCG_ADDR_A_BUFH) begin
        aBufH_r <= pwdata[7:0];
      end
      if (wrAcc && paddr == `TCG_ADDR_A_BUFL) begin
        aBufL_r <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // read mux and answer, no wait state
  // ----------------------------------------
  reg [7:0] rdByte;

  always @* begin
    case (paddr)
      `TCG_ADDR_C_BUF:  rdByte = cBuf_r;
      `TCG_ADDR_FLAGS:  rdByte = flags_r & mask_r;
      `TCG_ADDR_MASK:   rdByte = mask_r;
      `TCG_ADDR_B_CTRL: rdByte = bCtrl_r;
      `TCG_ADDR_B_BUFA: rdByte = bBufA_r;
      `TCG_ADDR_B_BUFB: rdByte = bBufB_r;
      `TCG_ADDR_A_CTRL: rdByte = {convLowBits, 1'b0, aCtrl_r};
      `TCG_ADDR_A_BUFH: rdByte = aBufH_r;
      `TCG_ADDR_A_BUFL: rdByte = aBufL_r;
      default:          rdByte = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
      prdata  <= (psel && !penable && !pwrite) ? {23'h000000, (paddr == `TCG_ADDR_C_BUF) & cRun_r,
                 rdByte} : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ### verification/tcg_timer_group_asserts.sv
`include "tcg_regs.vh"
`default_nettype none
// ----------------------------------------
// port checks
// ----------------------------------------
module tcg_timer_group_asserts (
  input wire logic        ref_clk,     // clock
  input wire logic        rst_n,       // reset
  input wire logic        psel,        // select
  input wire logic        penable,     // enable
  input wire logic        pwrite,      // direction
  input wire logic [11:0] paddr,       // address
  input wire logic [31:0] prdata,      // read data
  input wire logic        pready,      // ready
  input wire logic        pslverr,     // error
  input wire logic [1:0]  convLowBits, // conversion bits
  input wire logic [2:0]  irqFlags     // raw flags
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_READY: assert property (psel && !penable |=> pready) else $error("no ready");
  AST_ONE: assert property (pready |=> !pready) else $error("ready held");
  AST_IDLE: assert property (!psel |=> !pready) else $error("stray ready");
  AST_ERR: assert property (pready |-> pslverr == (paddr > 12'h020)) else $error("bad error");
  AST_ZERO: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("idle data");
  AST_CLR: assert property (|($past(irqFlags) & ~irqFlags) |->
    $past(pready && pwrite && paddr == `TCG_ADDR_FLAGS)) else $error("flag fell");
  AST_RSVD: assert property (pready && paddr == `TCG_ADDR_FLAGS |->
    (prdata & 32'hffffffba) == 32'h0) else $error("flag read bits");
  AST_CONV: assert property (pready && !pwrite && paddr == `TCG_ADDR_A_CTRL &&
    $stable(convLowBits)
    |-> prdata[7:5] == {convLowBits, 1'b0}) else $error("conversion bits");
endmodule
bind tcg_timer_group tcg_timer_group_asserts tcg_timer_group_asserts_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .convLowBits(convLowBits), .irqFlags(irqFlags));
`default_nettype wire

// ### verification/tb_tcg_timer_group.sv
`include "tcg_regs.vh"
`default_nettype none
module tb_tcg_timer_group;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, errv;
  logic        timerAPin, timerBPin, timerCPin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [1:0]  convLowBits;
  logic [2:0]  irqFlags;
  int          fails, num_checks, cyc;
  tcg_timer_group tcg_timer_group_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timerAPin(timerAPin), .timerBPin(timerBPin), .timerCPin(timerCPin),
    .convLowBits(convLowBits), .irqFlags(irqFlags));
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask
  task automatic waitFlag(input int i, input int lim);
    int n;
    n = 0;
    while (irqFlags[i] !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, irqFlags[i]}, 32'h1);
  endtask
  task automatic pulseB();
    timerBPin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    timerBPin <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic regTest();
    logic [11:0] adr [5];
    adr = '{`TCG_ADDR_C_BUF, `TCG_ADDR_B_BUFA, `TCG_ADDR_B_BUFB, `TCG_ADDR_A_BUFH,
            `TCG_ADDR_A_BUFL};
    rd(`TCG_ADDR_MASK, 32'h0);
    rd(`TCG_ADDR_A_CTRL, 32'h80);
    foreach (adr[k]) begin
      apb(1'b1, adr[k], 32'h5a + k);
      rd(adr[k], 32'h5a + k);
    end
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, errv}, 32'h1);
  endtask
  task automatic resetKeep();
    apb(1'b1, `TCG_ADDR_B_BUFA, 32'hc3);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`TCG_ADDR_B_BUFA, 32'hc3);
    rd(`TCG_ADDR_A_BUFL, 32'h0);
  endtask
  task automatic timerA();
    apb(1'b1, `TCG_ADDR_A_BUFL, 32'h3);
    apb(1'b1, `TCG_ADDR_A_CTRL, 32'h0c);
    waitFlag(1, 40);
    rd(`TCG_ADDR_FLAGS, 32'h0);
    apb(1'b1, `TCG_ADDR_A_CTRL, 32'h1c);
    apb(1'b1, `TCG_ADDR_MASK, 32'hff);
    rd(`TCG_ADDR_FLAGS, 32'h40);
    apb(1'b1, `TCG_ADDR_FLAGS, 32'hff);
    rd(`TCG_ADDR_FLAGS, 32'h40);
    apb(1'b1, `TCG_ADDR_FLAGS, 32'h0);
    repeat (30) @(posedge ref_clk);
    chk({31'h0, irqFlags[1]}, 32'h0);
    timerAPin <= 1'b1;
    waitFlag(1, 40);
    apb(1'b1, `TCG_ADDR_A_CTRL, 32'h0);
    apb(1'b1, `TCG_ADDR_FLAGS, 32'h0);
  endtask
  task automatic timerB();
    apb(1'b1, `TCG_ADDR_B_BUFA, 32'h2);
    apb(1'b1, `TCG_ADDR_B_CTRL, 32'h70);
    repeat (6) pulseB();
    rd(`TCG_ADDR_FLAGS, 32'h01);
    apb(1'b1, `TCG_ADDR_FLAGS, 32'h0);
    apb(1'b1, `TCG_ADDR_B_BUFA, 32'hff);
    apb(1'b1, `TCG_ADDR_B_BUFB, 32'hff);
    apb(1'b1, `TCG_ADDR_B_CTRL, 32'h68);
    repeat (600) @(posedge ref_clk);
    rd(`TCG_ADDR_B_BUFB, 32'hff);
    apb(1'b1, `TCG_ADDR_B_CTRL, 32'he8);
    apb(1'b0, `TCG_ADDR_B_BUFB, 32'h0);
    chk({31'h0, rdv > 0 && rdv < 8}, 32'h1);
    apb(1'b1, `TCG_ADDR_B_CTRL, 32'h08);
    apb(1'b1, `TCG_ADDR_B_CTRL, 32'h88);
    rd(`TCG_ADDR_B_BUFB, 32'h0);
  endtask
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    timerAPin = 1'b0;
    timerBPin = 1'b0;
    timerCPin = 1'b0;
    convLowBits = 2'b10;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    regTest();
    resetKeep();
    timerA();
    timerB();
    apb(1'b1, `TCG_ADDR_C_BUF, 32'h101);
    waitFlag(2, 1200);
    tally_and_finish();
  end
endmodule
`default_nettype wire
